// [mei_core.sv]
`timescale 1ns/1ps
// Overview of operation
// R1 - two push-pull interrupt pins carry events to the host
// R2 - pins active high after reset; invert bit makes both active low
// R3 - each function flags only when enabled; routing bit picks its pin
// R4 - host sets up functions and routing before enabling any interrupt
// R5 - host disables a function before reconfiguring it, then re-enables
// R6 - flags latch; new-sample flag holds until data reads consume the sample
// R7 - other latched flags clear when the flag register is read
// R8 - new-sample flag set while an unread sample exists, else clear
// R9 - single tap: above tap threshold for less than tap max time
// R10 - double tap: second short tap after latency and within span
// R11 - activity: any selected axis exceeds the activity threshold
// R12 - stillness: all selected axes below threshold longer than stillness time
// R13 - drop: all three axes below drop threshold longer than drop time
// R14 - drop always uses all axes, dc coupling, timer up to 1.28 s
// R15 - all functions run together; functions on one pin share it
// R16 - pin asserts while any enabled latched flag routed to it is set
module mei_core
	import mei_pkg::*;
#(
	parameter int TAP_TICK_CYCLES   = TAP_UNIT_CYCLES,
	parameter int LAT_TICK_CYCLES   = LAT_UNIT_CYCLES,
	parameter int STILL_TICK_CYCLES = STILL_UNIT_CYCLES,
	parameter int DROP_TICK_CYCLES  = DROP_UNIT_CYCLES
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               rst_n,
	// register access port
	input  wire logic [5:0]         reg_addr,
	input  wire logic               reg_wr_en,
	input  wire logic [7:0]         reg_wdata,
	input  wire logic               reg_rd_en,
	output logic      [7:0]         reg_rdata,
	// samples from the measurement path
	input  wire logic               sample_valid,
	input  wire logic signed [15:0] sample_x,
	input  wire logic signed [15:0] sample_y,
	input  wire logic signed [15:0] sample_z,
	// interrupt pins
	output logic                    irq_pin_one,
	output logic                    irq_pin_two
);
	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	logic [7:0] tap_threshold;
	logic [7:0] tap_max_time;
	logic [7:0] tap_latency;
	logic [7:0] second_tap_span;
	logic [7:0] activity_threshold;
	logic [7:0] stillness_threshold;
	logic [7:0] stillness_time;
	logic [7:0] motion_axis_control;
	logic [7:0] drop_threshold;
	logic [7:0] drop_time;
	logic [7:0] interrupt_enable_mask;
	logic [7:0] interrupt_pin_routing;
	logic [7:0] output_format_control;
	logic [7:0] interrupt_flags;

	// latest sample and the ac reference
	logic signed [15:0] x_axis_output;
	logic signed [15:0] y_axis_output;
	logic signed [15:0] z_axis_output;
	logic signed [15:0] ref_x;
	logic signed [15:0] ref_y;
	logic signed [15:0] ref_z;
	logic               ref_pending;

	// detector state
	logic       tap_above;
	logic       still_held;
	logic       drop_held;
	logic [8:0] still_count;
	logic [8:0] drop_count;
	logic       tick_tap;
	logic       tick_lat;
	logic       tick_still;
	logic       tick_drop;
	logic       single_hit;
	logic       double_hit;

	// ------------------------------------------------------------
	// register writes
	// ------------------------------------------------------------
	// plain storage; the host is trusted to disable a function around
	// reconfiguration, the logic does not lock anything out
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tap_threshold         <= REG_RESET;
			tap_max_time          <= REG_RESET;
			tap_latency           <= REG_RESET;
			second_tap_span       <= REG_RESET;
			activity_threshold    <= REG_RESET;
			stillness_threshold   <= REG_RESET;
			stillness_time        <= REG_RESET;
			motion_axis_control   <= REG_RESET;
			drop_threshold        <= REG_RESET;
			drop_time             <= REG_RESET;
			interrupt_enable_mask <= REG_RESET;
			interrupt_pin_routing <= REG_RESET;
			output_format_control <= REG_RESET;
		end else if (reg_wr_en) begin
			unique case (reg_addr)
				ADDR_TAP_THRESHOLD:       tap_threshold         <= reg_wdata;
				ADDR_TAP_MAX_TIME:        tap_max_time          <= reg_wdata;
				ADDR_TAP_LATENCY:         tap_latency           <= reg_wdata;
				ADDR_SECOND_TAP_SPAN:     second_tap_span       <= reg_wdata;
				ADDR_ACTIVITY_THRESHOLD:  activity_threshold    <= reg_wdata;
				ADDR_STILLNESS_THRESHOLD: stillness_threshold   <= reg_wdata;
				ADDR_STILLNESS_TIME:      stillness_time        <= reg_wdata;
				ADDR_MOTION_AXIS_CONTROL: motion_axis_control   <= reg_wdata;
				ADDR_DROP_THRESHOLD:      drop_threshold        <= reg_wdata;
				ADDR_DROP_TIME:           drop_time             <= reg_wdata;
				ADDR_INTERRUPT_ENABLE:    interrupt_enable_mask <= reg_wdata; // R3
				ADDR_INTERRUPT_ROUTING:   interrupt_pin_routing <= reg_wdata; // R3
				ADDR_OUTPUT_FORMAT:       output_format_control <= reg_wdata; // R2
				default: ;
			endcase
		end
	end

	// ------------------------------------------------------------
	// register reads
	// ------------------------------------------------------------
	// read data is registered, so it appears the cycle after reg_rd_en
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd_en) begin
			unique case (reg_addr)
				ADDR_TAP_THRESHOLD:       reg_rdata <= tap_threshold;
				ADDR_TAP_MAX_TIME:        reg_rdata <= tap_max_time;
				ADDR_TAP_LATENCY:         reg_rdata <= tap_latency;
				ADDR_SECOND_TAP_SPAN:     reg_rdata <= second_tap_span;
				ADDR_ACTIVITY_THRESHOLD:  reg_rdata <= activity_threshold;
				ADDR_STILLNESS_THRESHOLD: reg_rdata <= stillness_threshold;
				ADDR_STILLNESS_TIME:      reg_rdata <= stillness_time;
				ADDR_MOTION_AXIS_CONTROL: reg_rdata <= motion_axis_control;
				ADDR_DROP_THRESHOLD:      reg_rdata <= drop_threshold;
				ADDR_DROP_TIME:           reg_rdata <= drop_time;
				ADDR_INTERRUPT_ENABLE:    reg_rdata <= interrupt_enable_mask;
				ADDR_INTERRUPT_ROUTING:   reg_rdata <= interrupt_pin_routing;
				ADDR_INTERRUPT_FLAGS:     reg_rdata <= interrupt_flags;
				ADDR_OUTPUT_FORMAT:       reg_rdata <= output_format_control;
				6'h32:                    reg_rdata <= x_axis_output[7:0];
				6'h33:                    reg_rdata <= x_axis_output[15:8];
				6'h34:                    reg_rdata <= y_axis_output[7:0];
				6'h35:                    reg_rdata <= y_axis_output[15:8];
				6'h36:                    reg_rdata <= z_axis_output[7:0];
				6'h37:                    reg_rdata <= z_axis_output[15:8];
				default:                  reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// sample capture and ac reference
	// ------------------------------------------------------------
	// a new sample simply replaces the old one; no buffering here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			x_axis_output <= 16'sh0000;
			y_axis_output <= 16'sh0000;
			z_axis_output <= 16'sh0000;
		end else if (sample_valid) begin
			x_axis_output <= sample_x;
			y_axis_output <= sample_y;
			z_axis_output <= sample_z;
		end
	end

	// reference is retaken on the first sample after a relevant write,
	// so re-enabling an ac-coupled function starts from the current pose
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ref_x       <= 16'sh0000;
			ref_y       <= 16'sh0000;
			ref_z       <= 16'sh0000;
			ref_pending <= 1'b1;
		end else if (sample_valid && ref_pending) begin
			ref_x       <= sample_x;
			ref_y       <= sample_y;
			ref_z       <= sample_z;
			ref_pending <= 1'b0;
		end else if (reg_wr_en && (reg_addr == ADDR_INTERRUPT_ENABLE ||
			reg_addr == ADDR_MOTION_AXIS_CONTROL)) begin
			ref_pending <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// per-sample comparisons
	// ------------------------------------------------------------
	logic [15:0] act_mag [3];
	logic [15:0] still_mag [3];
	logic [15:0] dc_mag [3];
	logic        act_hit;
	logic        still_hit;
	logic        drop_hit;
	logic        tap_hit;

	always_comb begin
		act_mag[0]   = mei_dist(sample_x, motion_axis_control[BIT_ACT_AC] ? ref_x : 16'sh0000);
		act_mag[1]   = mei_dist(sample_y, motion_axis_control[BIT_ACT_AC] ? ref_y : 16'sh0000);
		act_mag[2]   = mei_dist(sample_z, motion_axis_control[BIT_ACT_AC] ? ref_z : 16'sh0000);
		still_mag[0] = mei_dist(sample_x, motion_axis_control[BIT_STILL_AC] ? ref_x : 16'sh0000);
		still_mag[1] = mei_dist(sample_y, motion_axis_control[BIT_STILL_AC] ? ref_y : 16'sh0000);
		still_mag[2] = mei_dist(sample_z, motion_axis_control[BIT_STILL_AC] ? ref_z : 16'sh0000);
		// drop ignores the coupling bits entirely
		dc_mag[0]    = mei_dist(sample_x, 16'sh0000); // R14
		dc_mag[1]    = mei_dist(sample_y, 16'sh0000); // R14
		dc_mag[2]    = mei_dist(sample_z, 16'sh0000); // R14
		act_hit   = 1'b0;
		still_hit = 1'b1;
		drop_hit  = 1'b1;
		tap_hit   = 1'b0;
		for (int i = 0; i < 3; i++) begin
			// axis enable bits run x, y, z from the high end down
			if (motion_axis_control[BIT_ACT_X - i] && mei_over(act_mag[i], activity_threshold))
				act_hit = 1'b1; // R11
			if (motion_axis_control[BIT_STILL_X - i] &&
				!mei_over(still_mag[i] + 16'h0001, stillness_threshold))
				still_hit = still_hit;
			else if (motion_axis_control[BIT_STILL_X - i])
				still_hit = 1'b0; // R12
			if (mei_over(dc_mag[i] + 16'h0001, drop_threshold))
				drop_hit = 1'b0; // R13
			if (mei_over(dc_mag[i], tap_threshold))
				tap_hit = 1'b1;
		end
		// with no axis selected stillness can never be seen
		if (motion_axis_control[BIT_STILL_X -: 3] == 3'b000)
			still_hit = 1'b0;
	end

	// ------------------------------------------------------------
	// time bases
	// ------------------------------------------------------------
	mei_tick_div #(.PERIOD(TAP_TICK_CYCLES)) u_tick_tap (
		.clk  (clk),
		.rst_n(rst_n),
		.tick (tick_tap)
	);
	mei_tick_div #(.PERIOD(LAT_TICK_CYCLES)) u_tick_lat (
		.clk  (clk),
		.rst_n(rst_n),
		.tick (tick_lat)
	);
	mei_tick_div #(.PERIOD(STILL_TICK_CYCLES)) u_tick_still (
		.clk  (clk),
		.rst_n(rst_n),
		.tick (tick_still)
	);
	mei_tick_div #(.PERIOD(DROP_TICK_CYCLES)) u_tick_drop (
		.clk  (clk),
		.rst_n(rst_n),
		.tick (tick_drop)
	);

	// ------------------------------------------------------------
	// tap detection
	// ------------------------------------------------------------
	// tap level is held between samples so the timer sees a steady level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			tap_above <= 1'b0;
		else if (sample_valid)
			tap_above <= tap_hit; // R9
	end

	mei_tap_detect u_tap (
		.clk       (clk),
		.rst_n     (rst_n),
		.above     (tap_above),
		.tick_dur  (tick_tap),
		.tick_lat  (tick_lat),
		.max_time  (tap_max_time),
		.latency   (tap_latency),
		.span      (second_tap_span),
		.single_hit(single_hit),
		.double_hit(double_hit)
	);

	// ------------------------------------------------------------
	// dwell timers
	// ------------------------------------------------------------
	// counters are one bit wider than the time so "longer than 255" fits;
	// the tick phase is free running, so the dwell may run up to one unit long
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			still_held  <= 1'b0;
			still_count <= 9'h000;
		end else if (sample_valid && !still_hit) begin
			still_held  <= 1'b0;
			still_count <= 9'h000;
		end else if (sample_valid && !still_held) begin
			still_held  <= 1'b1;
			still_count <= 9'h000;
		end else if (tick_still && still_held && still_count != 9'h1ff) begin
			still_count <= still_count + 9'h001; // R12
		end
	end

	// drop timer: 8 bits of 5 ms steps cover the full 1.28 s span
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			drop_held  <= 1'b0;
			drop_count <= 9'h000;
		end else if (sample_valid && !drop_hit) begin
			drop_held  <= 1'b0;
			drop_count <= 9'h000;
		end else if (sample_valid && !drop_held) begin
			drop_held  <= 1'b1;
			drop_count <= 9'h000;
		end else if (tick_drop && drop_held && drop_count != 9'h1ff) begin
			drop_count <= drop_count + 9'h001; // R14
		end
	end

	// ------------------------------------------------------------
	// latched flags
	// ------------------------------------------------------------
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic       data_read;

	always_comb begin
		flag_set = 8'h00;
		// one-shot sets when a dwell first passes its time
		flag_set[BIT_NEW_SAMPLE] = sample_valid; // R8
		flag_set[BIT_SINGLE_TAP] = single_hit;
		flag_set[BIT_DOUBLE_TAP] = double_hit;
		flag_set[BIT_ACTIVITY]   = sample_valid && act_hit; // R11
		flag_set[BIT_STILLNESS]  = tick_still && still_held &&
			still_count == {1'b0, stillness_time}; // R12
		flag_set[BIT_DROP]       = tick_drop && drop_held &&
			drop_count == {1'b0, drop_time}; // R13
		// only enabled functions latch anything, apart from sample state
		flag_set = flag_set & (interrupt_enable_mask | (8'h01 << BIT_NEW_SAMPLE)); // R3
		data_read = reg_rd_en && reg_addr >= ADDR_AXIS_FIRST && reg_addr <= ADDR_AXIS_LAST;
		flag_clr = 8'h00;
		flag_clr[BIT_NEW_SAMPLE] = data_read; // R6
		if (reg_rd_en && reg_addr == ADDR_INTERRUPT_FLAGS)
			flag_clr = flag_clr | (FLAG_IMPL_MASK & ~(8'h01 << BIT_NEW_SAMPLE)); // R7
	end

	// a set in the same cycle as its clear wins, so no event is lost
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			interrupt_flags <= REG_RESET;
		else
			interrupt_flags <= ((interrupt_flags & ~flag_clr) | flag_set) & FLAG_IMPL_MASK; // R6
	end

	// ------------------------------------------------------------
	// interrupt pins
	// ------------------------------------------------------------
	logic [7:0] live;

	assign live = interrupt_flags & interrupt_enable_mask; // R3

	// pins are always driven, both levels, straight from flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_pin_one <= 1'b0; // R2
			irq_pin_two <= 1'b0;
		end else begin
			irq_pin_one <= (|(live & ~interrupt_pin_routing)) ^
				output_format_control[BIT_INVERT]; // R16 R15 R1 R2
			irq_pin_two <= (|(live & interrupt_pin_routing)) ^
				output_format_control[BIT_INVERT]; // R16 R15 R1 R2
		end
	end
endmodule

// [mei_core_assertions.sv]
`timescale 1ns/1ps
module mei_core_checker
	import mei_pkg::*;
(
	// clock and reset
	input wire logic               clk,
	input wire logic               rst_n,
	// register port
	input wire logic [5:0]         reg_addr,
	input wire logic               reg_wr_en,
	input wire logic [7:0]         reg_wdata,
	input wire logic               reg_rd_en,
	input wire logic [7:0]         reg_rdata,
	// samples
	input wire logic               sample_valid,
	input wire logic signed [15:0] sample_x,
	input wire logic signed [15:0] sample_y,
	input wire logic signed [15:0] sample_z,
	// pins
	input wire logic               irq_pin_one,
	input wire logic               irq_pin_two
);
	logic [7:0] en_q;
	logic [7:0] map_q;
	logic       inv_q;
	wire logic  rd_flg = reg_rd_en && reg_addr == 6'h30;
	wire logic  rd_dat = reg_rd_en && reg_addr >= 6'h32 && reg_addr <= 6'h37;
	wire logic  unmap = reg_addr < 6'h1d || (reg_addr > 6'h1d && reg_addr < 6'h21)
		|| (reg_addr > 6'h29 && reg_addr < 6'h2e) || reg_addr > 6'h37;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// shadow of the pin setup, so pin levels can be predicted from writes alone
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 8'h00;
			map_q <= 8'h00;
			inv_q <= 1'b0;
		end else if (reg_wr_en) begin
			if (reg_addr == 6'h2e) en_q <= reg_wdata;
			if (reg_addr == 6'h2f) map_q <= reg_wdata;
			if (reg_addr == 6'h31) inv_q <= reg_wdata[BIT_INVERT];
		end
	end
	chk_rdata_holds: assert property (!reg_rd_en |=> $stable(reg_rdata))
		else $error("read data moved without a read");
	chk_unmapped_zero: assert property (reg_rd_en && unmap |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	chk_sample_flag_set: assert property (sample_valid ##1 !rd_dat ##1 rd_flg
		|=> reg_rdata[BIT_NEW_SAMPLE]) else $error("new sample flag missing");
	chk_data_read_clears: assert property ((rd_dat && !sample_valid) ##1 !sample_valid
		##1 rd_flg |=> !reg_rdata[BIT_NEW_SAMPLE]) else $error("data read left flag set");
	chk_flag_read_clears: assert property ((rd_flg && !sample_valid) ##1 !sample_valid
		##1 rd_flg |=> reg_rdata[6:4] == 3'h0) else $error("flag read did not clear");
	chk_idle_pin_level: assert property ($past(en_q) == 8'h00 && $stable(inv_q)
		|-> irq_pin_one == inv_q && irq_pin_two == inv_q) else $error("idle pin level wrong");
	chk_pin_one_route: assert property ((sample_valid && !reg_wr_en && en_q[7] && !map_q[7])
		##1 !reg_wr_en |=> irq_pin_one != inv_q) else $error("pin one not asserted");
	chk_pin_two_route: assert property ((sample_valid && !reg_wr_en && en_q[7] && map_q[7])
		##1 !reg_wr_en |=> irq_pin_two != inv_q) else $error("pin two not asserted");
endmodule
bind mei_core mei_core_checker u_chk (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata,
	.reg_rd_en, .reg_rdata, .sample_valid, .sample_x, .sample_y, .sample_z,
	.irq_pin_one, .irq_pin_two);

// [mei_host_model.sv]
`timescale 1ns/1ps
module mei_host_model (
	// pins as driven by the device
	input wire logic irq_pin_one,
	input wire logic irq_pin_two,
	// host knows the polarity it programmed
	input wire logic active_low,
	// event seen by the host, active high
	output logic     one_act,
	output logic     two_act
);
	// host folds the programmed polarity back out of both pins
	assign one_act = irq_pin_one ^ active_low;
	assign two_act = irq_pin_two ^ active_low;
endmodule

// [mei_pkg.sv]
package mei_pkg;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [5:0] ADDR_TAP_THRESHOLD       = 6'h1d;
	localparam logic [5:0] ADDR_TAP_MAX_TIME        = 6'h21;
	localparam logic [5:0] ADDR_TAP_LATENCY         = 6'h22;
	localparam logic [5:0] ADDR_SECOND_TAP_SPAN     = 6'h23;
	localparam logic [5:0] ADDR_ACTIVITY_THRESHOLD  = 6'h24;
	localparam logic [5:0] ADDR_STILLNESS_THRESHOLD = 6'h25;
	localparam logic [5:0] ADDR_STILLNESS_TIME      = 6'h26;
	localparam logic [5:0] ADDR_MOTION_AXIS_CONTROL = 6'h27;
	localparam logic [5:0] ADDR_DROP_THRESHOLD      = 6'h28;
	localparam logic [5:0] ADDR_DROP_TIME           = 6'h29;
	localparam logic [5:0] ADDR_INTERRUPT_ENABLE    = 6'h2e;
	localparam logic [5:0] ADDR_INTERRUPT_ROUTING   = 6'h2f;
	localparam logic [5:0] ADDR_INTERRUPT_FLAGS     = 6'h30;
	localparam logic [5:0] ADDR_OUTPUT_FORMAT       = 6'h31;
	localparam logic [5:0] ADDR_AXIS_FIRST          = 6'h32;
	localparam logic [5:0] ADDR_AXIS_LAST           = 6'h37;

	// ------------------------------------------------------------
	// field positions and reset values
	// ------------------------------------------------------------
	localparam int BIT_NEW_SAMPLE = 7;
	localparam int BIT_SINGLE_TAP = 6;
	localparam int BIT_DOUBLE_TAP = 5;
	localparam int BIT_ACTIVITY   = 4;
	localparam int BIT_STILLNESS  = 3;
	localparam int BIT_DROP       = 2;
	localparam int BIT_INVERT     = 5;
	localparam int BIT_ACT_AC     = 7;
	localparam int BIT_ACT_X      = 6;
	localparam int BIT_STILL_AC   = 3;
	localparam int BIT_STILL_X    = 2;
	localparam logic [7:0] REG_RESET      = 8'h00;
	localparam logic [7:0] FLAG_IMPL_MASK = 8'hfc;
	localparam int THR_SHIFT = 4;

	// ------------------------------------------------------------
	// time bases
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS    = 20;
	localparam int TAP_UNIT_NS      = 625000;
	localparam int LAT_UNIT_NS      = 1250000;
	localparam int STILL_UNIT_NS    = 1000000000;
	localparam int DROP_UNIT_NS     = 5000000;
	localparam int TAP_UNIT_CYCLES   = TAP_UNIT_NS / CLK_PERIOD_NS;
	localparam int LAT_UNIT_CYCLES   = LAT_UNIT_NS / CLK_PERIOD_NS;
	localparam int STILL_UNIT_CYCLES = STILL_UNIT_NS / CLK_PERIOD_NS;
	localparam int DROP_UNIT_CYCLES  = DROP_UNIT_NS / CLK_PERIOD_NS;

	// distance of a sample from a reference, saturated to 16 bits
	function automatic logic [15:0] mei_dist(input logic signed [15:0] a,
		input logic signed [15:0] b);
		logic signed [16:0] d;
		logic [16:0]        m;
		d = 17'(a) - 17'(b);
		m = d[16] ? 17'(-d) : 17'(d);
		// clamp one short of all ones so the strict below tests may add one safely
		return (m[16] || m[15:0] == 16'hffff) ? 16'hfffe : m[15:0];
	endfunction

	// threshold registers count in steps of sixteen sample lsbs
	function automatic logic mei_over(input logic [15:0] mag, input logic [7:0] thr);
		return mag > ({8'h00, thr} << THR_SHIFT);
	endfunction

endpackage

// [mei_tap_detect.sv]
`timescale 1ns/1ps
module mei_tap_detect
	import mei_pkg::*;
(
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// level and time bases
	input  wire logic       above,
	input  wire logic       tick_dur,
	input  wire logic       tick_lat,
	// settings
	input  wire logic [7:0] max_time,
	input  wire logic [7:0] latency,
	input  wire logic [7:0] span,
	// detections
	output logic            single_hit,
	output logic            double_hit
);
	typedef enum {IDLE, FIRST, LATENT, WINDOW, SECOND, WAIT_LOW} mei_tap_state_t;
	mei_tap_state_t state;
	logic [7:0]     count;

	// short pulse detection and second tap qualification
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state      <= IDLE;
			count      <= 8'h00;
			single_hit <= 1'b0;
			double_hit <= 1'b0;
		end else begin
			single_hit <= 1'b0;
			double_hit <= 1'b0;
			unique case (state)
				IDLE: begin
					count <= 8'h00;
					if (above && max_time != 8'h00)
						state <= FIRST;
				end
				FIRST: begin
					if (!above) begin
						single_hit <= 1'b1; // R9
						count      <= 8'h00;
						// a zero latency or span leaves only single taps
						state      <= (latency != 8'h00 && span != 8'h00) ? LATENT : IDLE;
					end else if (tick_dur) begin
						count <= count + 8'h01;
						if (count + 8'h01 >= max_time)
							state <= WAIT_LOW; // too long to be a tap
					end
				end
				LATENT: begin
					if (above)
						state <= WAIT_LOW; // second tap started too early
					else if (tick_lat) begin
						count <= count + 8'h01;
						if (count + 8'h01 >= latency) begin
							count <= 8'h00;
							state <= WINDOW;
						end
					end
				end
				WINDOW: begin
					if (above) begin
						count <= 8'h00;
						state <= SECOND; // R10
					end else if (tick_lat) begin
						count <= count + 8'h01;
						if (count + 8'h01 >= span)
							state <= IDLE;
					end
				end
				SECOND: begin
					if (!above) begin
						double_hit <= 1'b1; // R10
						state      <= IDLE;
					end else if (tick_dur) begin
						count <= count + 8'h01;
						if (count + 8'h01 >= max_time)
							state <= WAIT_LOW;
					end
				end
				WAIT_LOW: begin
					if (!above)
						state <= IDLE;
				end
			endcase
		end
	end
endmodule

// [mei_tick_div.sv]
`timescale 1ns/1ps
module mei_tick_div #(
	parameter int PERIOD = 4
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_n,
	// one-cycle enable every PERIOD cycles
	output logic      tick
);
	logic [31:0] count;

	// free running so every time base stays phase stable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count <= 32'h0000_0000;
			tick  <= 1'b0;
		end else if (count == 32'(PERIOD - 1)) begin
			count <= 32'h0000_0000;
			tick  <= 1'b1;
		end else begin
			count <= count + 32'h0000_0001;
			tick  <= 1'b0;
		end
	end
endmodule

// [testbench.sv]
`timescale 1ns/1ps
module testbench
	import mei_pkg::*;
;
	logic clk = 1'b0, rst_n, reg_wr_en, reg_rd_en, sample_valid, inv, p1, p2, one_act, two_act;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, d;
	logic signed [15:0] sx, sy, sz;
	int fails, checks_done;
	logic [5:0] ra [12] = '{6'h1d, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27,
		6'h28, 6'h29, 6'h2e, 6'h2f};
	// counts shortened so the timed detectors finish in a few hundred cycles
	mei_core #(.TAP_TICK_CYCLES(4), .LAT_TICK_CYCLES(8), .STILL_TICK_CYCLES(16),
		.DROP_TICK_CYCLES(8)) dut (.clk, .rst_n, .reg_addr, .reg_wr_en, .reg_wdata,
		.reg_rd_en, .reg_rdata, .sample_valid, .sample_x(sx), .sample_y(sy), .sample_z(sz),
		.irq_pin_one(p1), .irq_pin_two(p2));
	mei_host_model host (.irq_pin_one(p1), .irq_pin_two(p2), .active_low(inv), .one_act,
		.two_act);
	// ----
	// access tasks
	// ----
	task check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [5:0] a, input logic [7:0] v);
		@(negedge clk);
		{reg_addr, reg_wdata, reg_wr_en} = {a, v, 1'b1};
		@(negedge clk);
		reg_wr_en = 1'b0;
	endtask
	task rdc(input logic [5:0] a, input logic [7:0] exp);
		@(negedge clk);
		{reg_addr, reg_rd_en} = {a, 1'b1};
		@(negedge clk);
		reg_rd_en = 1'b0;
		check(reg_rdata, exp);
	endtask
	task smp(input logic signed [15:0] x, input logic signed [15:0] y, input logic signed [15:0] z);
		@(negedge clk);
		{sx, sy, sz, sample_valid} = {x, y, z, 1'b1};
		@(negedge clk);
		sample_valid = 1'b0;
	endtask
	task summarize;
		if (fails == 0 && checks_done > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// free-running clock; inputs only move on the falling edge
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// watchdog: the sequence needs well under a thousand cycles
	initial begin
		#1000000;
		fails++;
		summarize();
	end
	// ----
	// main sequence
	// ----
	initial begin
		{rst_n, reg_wr_en, reg_rd_en, sample_valid, inv, reg_addr, reg_wdata} = '0;
		{sx, sy, sz} = '0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		for (int i = 0; i < 12; i++) rdc(ra[i], 8'h00);
		for (int i = 0; i < 12; i++) begin
			wr(ra[i], 8'ha5);
			rdc(ra[i], 8'ha5);
			wr(ra[i], 8'h00);
		end
		wr(6'h30, 8'hff);
		rdc(6'h30, 8'h00);
		rdc(6'h38, 8'h00);
		check({6'h0, p1, p2}, 8'h00);
		wr(6'h31, 8'h20);
		inv = 1'b1;
		rdc(6'h31, 8'h20);
		check({6'h0, p1, p2}, 8'h03);
		wr(6'h31, 8'h00);
		inv = 1'b0;
		wr(6'h2e, 8'h80);
		smp(16'h1234, 16'h0055, -16'sd2);
		@(negedge clk);
		check({6'h0, one_act, two_act}, 8'h02);
		wr(6'h2f, 8'h80);
		@(negedge clk);
		check({6'h0, one_act, two_act}, 8'h01);
		wr(6'h31, 8'h20);
		inv = 1'b1;
		@(negedge clk);
		check({7'h0, p2}, 8'h00);
		rdc(6'h32, 8'h34);
		rdc(6'h33, 8'h12);
		check({7'h0, two_act}, 8'h00);
		rdc(6'h30, 8'h00);
		smp(16'sd0, 16'sd0, 16'sd0);
		@(negedge clk);
		check({7'h0, two_act}, 8'h01);
		wr(6'h31, 8'h00);
		inv = 1'b0;
		// activity: strictly above sixteen lsbs per threshold step
		wr(6'h24, 8'h01);
		wr(6'h27, 8'h70);
		wr(6'h2e, 8'h10);
		smp(16'sd100, 16'sd0, 16'sd0);
		rdc(6'h30, 8'h90);
		rdc(6'h30, 8'h80);
		rdc(6'h32, 8'h64);
		smp(-16'sd16, 16'sd0, 16'sd0);
		rdc(6'h30, 8'h80);
		// tap: short pulse counts, long pulse does not
		wr(6'h2e, 8'h00);
		wr(6'h1d, 8'h01);
		wr(6'h21, 8'h04);
		wr(6'h2e, 8'h40);
		smp(16'sd200, 16'sd0, 16'sd0);
		smp(16'sd0, 16'sd0, 16'sd0);
		// the tap flag lands three cycles after the falling sample
		@(negedge clk);
		rdc(6'h30, 8'hc0);
		smp(16'sd200, 16'sd0, 16'sd0);
		repeat (30) @(negedge clk);
		smp(16'sd0, 16'sd0, 16'sd0);
		rdc(6'h30, 8'h80);
		// double tap: second short pulse after the latency, inside the span
		wr(6'h2e, 8'h00);
		wr(6'h22, 8'h01);
		wr(6'h23, 8'h08);
		wr(6'h2e, 8'h60);
		smp(16'sd200, 16'sd0, 16'sd0);
		smp(16'sd0, 16'sd0, 16'sd0);
		repeat (10) @(negedge clk);
		smp(16'sd200, 16'sd0, 16'sd0);
		smp(16'sd0, 16'sd0, 16'sd0);
		@(negedge clk);
		rdc(6'h30, 8'he0);
		// stillness on pin one and drop on pin two run side by side
		wr(6'h2e, 8'h00);
		wr(6'h25, 8'h02);
		wr(6'h26, 8'h01);
		wr(6'h27, 8'h07);
		wr(6'h28, 8'h02);
		wr(6'h29, 8'h01);
		wr(6'h2f, 8'h04);
		wr(6'h2e, 8'h0c);
		repeat (20) smp(16'sd5, -16'sd5, 16'sd5);
		check({6'h0, one_act, two_act}, 8'h03);
		rdc(6'h30, 8'h8c);
		summarize();
	end
endmodule
